// >>> pkg/nvwl_pkg.sv
// How it works
// - User words writable per exception fields.
// - Three exception fields decide permission.
// - Exception fields reset to zero.
// - Unlocked: word two free with bypass.
// - Word one free needs enable and bypass.
// - Locked without lock bypass: refuse all.
// - Locked with bypass: user words only.
// - Data registers hold 32 bits until start.
// - Start bit copies data to address.
// - Done flag at bit 0 of 0x20.
// - Store write takes up to 24 ms.
// - Shadow write completes in one cycle.
// - Violation ends write, sets done, warns.
// - Aborted store write sets error flag.
// - Code 0b0001 lowers read threshold.
// - Code 0b0010 raises read threshold.
// - Margin codes persist and read back.
// - Five-byte keycode grants write access.
// - Lock 0xC blocks store, 0x3 both.
// - Shadow sits 0x40 above store address.
package nvwl_pkg;
   // Each register is one bus word, at four times its index.
   localparam logic [5:0] NVWL_IDX_ADDR = 6'h02;
   localparam logic [5:0] NVWL_IDX_DATA_HI = 6'h04;
   localparam logic [5:0] NVWL_IDX_DATA_LO = 6'h06;
   localparam logic [5:0] NVWL_IDX_CTRL = 6'h08;
   localparam logic [5:0] NVWL_IDX_KEY = 6'h3C;
   localparam logic [7:0] NVWL_OFS_ADDR = {NVWL_IDX_ADDR, 2'h0};
   localparam logic [7:0] NVWL_OFS_DATA_HI = {NVWL_IDX_DATA_HI, 2'h0};
   localparam logic [7:0] NVWL_OFS_DATA_LO = {NVWL_IDX_DATA_LO, 2'h0};
   localparam logic [7:0] NVWL_OFS_CTRL = {NVWL_IDX_CTRL, 2'h0};
   localparam logic [7:0] NVWL_OFS_KEY = {NVWL_IDX_KEY, 2'h0};
   localparam logic [7:0] NVWL_OFS_CFG = 8'h40;
   localparam logic [7:0] NVWL_OFS_ERR = 8'h44;
   localparam logic [7:0] NVWL_OFS_SPECIAL = 8'h48;
   localparam int NVWL_START_BIT = 15;
   localparam int NVWL_WIP_BIT = 8;
   localparam int NVWL_DONE_BIT = 0;
   localparam int NVWL_VIOL_BIT = 1;
   localparam logic [7:0] NVWL_USER_TWO = 8'h17;
   localparam logic [7:0] NVWL_USER_ONE = 8'h1F;
   localparam logic [7:0] NVWL_SHADOW_OFS = 8'h40;
   localparam logic [3:0] NVWL_LOCK_NONE = 4'h0;
   localparam logic [3:0] NVWL_LOCK_STORE = 4'hC;
   localparam logic [3:0] NVWL_LOCK_ALL = 4'h3;
   localparam logic [3:0] NVWL_MARGIN_LOW = 4'h1;
   localparam logic [3:0] NVWL_MARGIN_HIGH = 4'h2;
   localparam logic [1:0] NVWL_THR_NORMAL = 2'h0;
   localparam logic [1:0] NVWL_THR_LOW = 2'h1;
   localparam logic [1:0] NVWL_THR_HIGH = 2'h2;
   localparam logic [7:0] NVWL_KEY0 = 8'h00;
   localparam logic [7:0] NVWL_KEY1 = 8'h27;
   localparam logic [7:0] NVWL_KEY2 = 8'h81;
   localparam logic [7:0] NVWL_KEY3 = 8'h1F;
   localparam logic [7:0] NVWL_KEY4 = 8'h77;
   localparam int NVWL_CLK_MHZ = 200;
   localparam int NVWL_NV_WRITE_MS = 24;
   localparam int NVWL_NV_WRITE_CYC = NVWL_NV_WRITE_MS * 1000 * NVWL_CLK_MHZ;
   localparam logic [31:0] NVWL_RST_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {NVWL_IDLE, NVWL_DECIDE, NVWL_NV_BUSY}
      nvwl_state_t;
endpackage

// >>> hw/nvwl_permit.sv
`timescale 1ns/1ps
module nvwl_permit
   import nvwl_pkg::*;
(
   input wire logic [7:0] i_addr,
   input wire logic [3:0] i_lock,
   input wire logic i_user_en,
   input wire logic i_lock_byp,
   input wire logic i_unlock_byp,
   input wire logic i_keyed,
   output logic o_allow,
   output logic o_shadow
);
   logic [7:0] base;
   logic is_two;
   logic is_one;
   logic lock_hits;
   always_comb
   begin
      o_shadow = i_addr[6];
      base = i_addr & ~NVWL_SHADOW_OFS;
      is_two = base == NVWL_USER_TWO;
      is_one = base == NVWL_USER_ONE;
      // Store lock leaves shadow open; full lock covers both.
      lock_hits = i_lock == NVWL_LOCK_ALL ||
         (i_lock == NVWL_LOCK_STORE && !o_shadow);
      if (!lock_hits)
      begin
         if (is_two && i_unlock_byp)
            o_allow = 1'b1;
         else if (is_one && i_user_en && i_unlock_byp)
            o_allow = 1'b1;
         else
            o_allow = i_keyed;
      end
      else if (!i_lock_byp)
         o_allow = 1'b0;
      else if (is_two || (is_one && i_user_en))
         o_allow = i_unlock_byp || i_keyed;
      else
         o_allow = 1'b0;
   end
endmodule

// >>> hw/nvwl_top.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module nvwl_top
   import nvwl_pkg::*;
#(
   parameter int NV_WRITE_CYC = nvwl_pkg::NVWL_NV_WRITE_CYC
)
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_nv_abort,
   output logic o_nv_we,
   output logic o_sh_we,
   output logic [7:0] o_wr_addr,
   output logic [31:0] o_wr_data,
   output logic [1:0] o_read_thr
);
   import nvwl_pkg::*;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic abort_s1;
   logic abort_s2;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] ext_addr;
   logic [31:0] ext_data;
   logic [3:0] lock;
   logic user_en;
   logic lock_byp;
   logic unlock_byp;
   logic keyed;
   logic [2:0] key_step;
   logic [3:0] special;
   logic done;
   logic viol_warn;
   logic viol_err;
   logic busy;
   logic allow;
   logic shadow;
   logic addr_ok;
   logic start_req;
   logic [31:0] nv_cnt;
   nvwl_state_t state;
   logic [31:0] next_rdata;

   assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
   assign rd_acc = i_psel && !i_penable && !i_pwrite;
   assign addr_ok = i_paddr == NVWL_OFS_ADDR || i_paddr == NVWL_OFS_DATA_HI
      || i_paddr == NVWL_OFS_DATA_LO || i_paddr == NVWL_OFS_CTRL
      || i_paddr == NVWL_OFS_KEY || i_paddr == NVWL_OFS_CFG
      || i_paddr == NVWL_OFS_ERR || i_paddr == NVWL_OFS_SPECIAL;
   assign start_req = wr_acc && i_paddr == NVWL_OFS_CTRL && i_pstrb[1]
      && i_pwdata[NVWL_START_BIT];
   assign busy = state != NVWL_IDLE;

   // Ready in the access phase: one wait-free cycle after setup.
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !addr_ok;
      end
   end

   // ----------------------------------------------------------------
   // Write registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ext_addr <= 8'h00;
         ext_data <= NVWL_RST_DATA;
      end
      else if (wr_acc)
      begin
         if (i_paddr == NVWL_OFS_ADDR && i_pstrb[0])
            ext_addr <= i_pwdata[7:0];
         // Data held untouched between loads; MSB in the high word.
         if (i_paddr == NVWL_OFS_DATA_HI && i_pstrb[1:0] == 2'b11)
            ext_data[31:16] <= i_pwdata[15:0];
         if (i_paddr == NVWL_OFS_DATA_LO && i_pstrb[1:0] == 2'b11)
            ext_data[15:0] <= i_pwdata[15:0];
      end
   end

   // Exception fields and lock; all zero after power-on.
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         user_en <= 1'b0;
         lock_byp <= 1'b0;
         unlock_byp <= 1'b0;
         lock <= NVWL_LOCK_NONE;
      end
      else if (wr_acc && i_paddr == NVWL_OFS_CFG && i_pstrb[0])
      begin
         user_en <= i_pwdata[4];
         lock_byp <= i_pwdata[5];
         unlock_byp <= i_pwdata[6];
         // A lock once set cannot be reversed.
         if (lock == NVWL_LOCK_NONE)
            lock <= i_pwdata[3:0];
      end
   end

   // ----------------------------------------------------------------
   // Keycode
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         key_step <= 3'd0;
         keyed <= 1'b0;
      end
      else if (wr_acc && i_paddr == NVWL_OFS_KEY && i_pstrb[1] && !keyed)
      begin
         case (key_step)
            3'd0: key_step <= i_pwdata[15:8] == NVWL_KEY0 ? 3'd1 : 3'd0;
            3'd1: key_step <= i_pwdata[15:8] == NVWL_KEY1 ? 3'd2 : 3'd0;
            3'd2: key_step <= i_pwdata[15:8] == NVWL_KEY2 ? 3'd3 : 3'd0;
            3'd3: key_step <= i_pwdata[15:8] == NVWL_KEY3 ? 3'd4 : 3'd0;
            3'd4:
            begin
               keyed <= i_pwdata[15:8] == NVWL_KEY4;
               key_step <= 3'd0;
            end
            default: key_step <= 3'd0;
         endcase
      end
   end

   nvwl_permit u_permit
   (
      .i_addr(ext_addr),
      .i_lock(lock),
      .i_user_en(user_en),
      .i_lock_byp(lock_byp),
      .i_unlock_byp(unlock_byp),
      .i_keyed(keyed),
      .o_allow(allow),
      .o_shadow(shadow)
   );

   // ----------------------------------------------------------------
   // Extended write sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         abort_s1 <= 1'b0;
         abort_s2 <= 1'b0;
      end
      else
      begin
         abort_s1 <= i_nv_abort;
         abort_s2 <= abort_s1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state <= NVWL_IDLE;
         done <= 1'b0;
         viol_warn <= 1'b0;
         viol_err <= 1'b0;
         nv_cnt <= 32'h0000_0000;
         o_nv_we <= 1'b0;
         o_sh_we <= 1'b0;
         o_wr_addr <= 8'h00;
         o_wr_data <= NVWL_RST_DATA;
      end
      else
      begin
         o_nv_we <= 1'b0;
         o_sh_we <= 1'b0;
         if (wr_acc && i_paddr == NVWL_OFS_ERR && i_pstrb[0])
         begin
            if (i_pwdata[NVWL_VIOL_BIT])
               viol_warn <= 1'b0;
            if (i_pwdata[NVWL_DONE_BIT])
               viol_err <= 1'b0;
         end
         case (state)
            NVWL_IDLE:
               if (start_req)
               begin
                  done <= 1'b0;
                  state <= NVWL_DECIDE;
               end
            NVWL_DECIDE:
            begin
               o_wr_addr <= ext_addr;
               o_wr_data <= ext_data;
               if (!allow)
               begin
                  done <= 1'b1;
                  viol_warn <= 1'b1;
                  state <= NVWL_IDLE;
               end
               else if (shadow)
               begin
                  o_sh_we <= 1'b1;
                  done <= 1'b1;
                  state <= NVWL_IDLE;
               end
               else
               begin
                  o_nv_we <= 1'b1;
                  nv_cnt <= 32'h0000_0000;
                  state <= NVWL_NV_BUSY;
               end
            end
            NVWL_NV_BUSY:
            begin
               nv_cnt <= nv_cnt + 32'h0000_0001;
               if (abort_s2)
               begin
                  viol_err <= 1'b1;
                  viol_warn <= 1'b1;
                  done <= 1'b1;
                  state <= NVWL_IDLE;
               end
               else if (nv_cnt >= 32'(NV_WRITE_CYC - 1))
               begin
                  done <= 1'b1;
                  state <= NVWL_IDLE;
               end
            end
            default: state <= NVWL_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Margin threshold
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         special <= 4'h0;
         o_read_thr <= NVWL_THR_NORMAL;
      end
      else
      begin
         if (wr_acc && i_paddr == NVWL_OFS_SPECIAL && i_pstrb[0])
            special <= i_pwdata[3:0];
         if (special == NVWL_MARGIN_LOW)
            o_read_thr <= NVWL_THR_LOW;
         else if (special == NVWL_MARGIN_HIGH)
            o_read_thr <= NVWL_THR_HIGH;
         else
            o_read_thr <= NVWL_THR_NORMAL;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (i_paddr)
         NVWL_OFS_ADDR: next_rdata[7:0] = ext_addr;
         NVWL_OFS_DATA_HI: next_rdata[15:0] = ext_data[31:16];
         NVWL_OFS_DATA_LO: next_rdata[15:0] = ext_data[15:0];
         NVWL_OFS_CTRL:
         begin
            next_rdata[NVWL_WIP_BIT] = busy;
            next_rdata[NVWL_DONE_BIT] = done;
         end
         NVWL_OFS_CFG:
            next_rdata[6:0] = {unlock_byp, lock_byp, user_en, lock};
         NVWL_OFS_ERR:
            next_rdata[1:0] = {viol_warn, viol_err};
         NVWL_OFS_SPECIAL: next_rdata[3:0] = special;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_prdata <= 32'h0000_0000;
      else if (rd_acc)
         o_prdata <= next_rdata;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_locked_refuse: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == NVWL_DECIDE && lock == NVWL_LOCK_ALL && !lock_byp
      |=> !o_nv_we && !o_sh_we && done && viol_warn)
      else $error("locked write not refused");
   a_viol_done: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == NVWL_DECIDE && !allow |=> done && state == NVWL_IDLE)
      else $error("violation did not end write");
   a_shadow_one: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == NVWL_DECIDE && allow && shadow |=> o_sh_we && done)
      else $error("shadow write not single cycle");
   a_start_clear: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == NVWL_IDLE && start_req |=> !done ##1 (busy || done))
      else $error("done not cleared on start");
   a_abort_err: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == NVWL_NV_BUSY && abort_s2 |=> viol_err && done)
      else $error("abort did not set error");
   a_user_two: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      lock == NVWL_LOCK_NONE && unlock_byp && ext_addr == NVWL_USER_TWO
      |-> allow)
      else $error("user word two refused");
   a_margin_low: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      special == NVWL_MARGIN_LOW |=> o_read_thr == NVWL_THR_LOW)
      else $error("low threshold not selected");
   a_margin_high: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      special == NVWL_MARGIN_HIGH |=> o_read_thr == NVWL_THR_HIGH)
      else $error("high threshold not selected");
   a_data_copy: assert property (
      @(posedge i_sys_clk) disable iff (!i_rstn)
      state == NVWL_DECIDE |=> o_wr_data == $past(ext_data))
      else $error("write data not copied");
endmodule

// >>> tb/nvwl_store_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Store behind the block: records writes and can fail one on command.
// ----------------------------------------
module nvwl_store_model
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_we,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_data,
   input wire logic i_abort_cmd,
   output logic o_abort,
   output logic [7:0] o_count,
   output logic [7:0] o_last_addr,
   output logic [31:0] o_last_data
);
   logic [3:0] abort_cnt;
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_count <= 8'h00;
         o_last_addr <= 8'h00;
         o_last_data <= 32'h0000_0000;
         abort_cnt <= 4'h0;
      end
      else if (i_we)
      begin
         o_count <= o_count + 8'h01;
         o_last_addr <= i_addr;
         o_last_data <= i_data;
         abort_cnt <= i_abort_cmd ? 4'h8 : 4'h0;
      end
      else if (abort_cnt != 4'h0)
      begin
         abort_cnt <= abort_cnt - 4'h1;
      end
   end
   // The abort level is held for four cycles so the 2-flop sync sees it.
   assign o_abort = (abort_cnt != 4'h0) && (abort_cnt < 4'h5);
endmodule

// >>> tb/nvwl_top_tb.sv
`timescale 1ns/1ps
module nvwl_top_tb;
   import nvwl_pkg::*;
   logic clk, rstn, psel, penable, pwrite, abort_cmd, nv_we, sh_we, nv_abort;
   logic [7:0] paddr, wr_addr, m_count, m_addr;
   logic [31:0] pwdata, prdata, wr_data, m_data, r;
   logic [3:0] pstrb, code;
   logic pready, pslverr;
   logic [1:0] read_thr, thr;
   int errors = 0;
   int checks = 0;
   int sh_cnt = 0;
   nvwl_top #(.NV_WRITE_CYC(20)) dut (.i_sys_clk(clk), .i_rstn(rstn),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_nv_abort(nv_abort), .o_nv_we(nv_we), .o_sh_we(sh_we),
      .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_read_thr(read_thr));
   nvwl_store_model store (.i_clk(clk), .i_rstn(rstn), .i_we(nv_we),
      .i_addr(wr_addr), .i_data(wr_data), .i_abort_cmd(abort_cmd),
      .o_abort(nv_abort), .o_count(m_count), .o_last_addr(m_addr),
      .o_last_data(m_data));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (sh_we === 1'b1)
         sh_cnt = sh_cnt + 1;
   end
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      chk("access cycles", 32'h1, 32'(n));
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic reset_dut();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
   endtask
   task automatic setcfg(input logic [31:0] v);
      wr(NVWL_OFS_CFG, v);
   endtask
   // Kind: 0 refused, 1 store, 2 shadow, 3 store aborted.
   task automatic xw(input logic [7:0] a, input logic [31:0] d, input int k);
      int n0, s0, i;
      n0 = int'(m_count);
      s0 = sh_cnt;
      abort_cmd <= (k == 3);
      wr(NVWL_OFS_ERR, 32'h0000_0003);
      wr(NVWL_OFS_ADDR, {24'h0, a});
      wr(NVWL_OFS_DATA_HI, {16'h0, d[31:16]});
      wr(NVWL_OFS_DATA_LO, {16'h0, d[15:0]});
      wr(NVWL_OFS_CTRL, 32'h0000_8000);
      // A second start only while a store write is still running.
      if (k == 1 || k == 3)
         wr(NVWL_OFS_CTRL, 32'h0000_8000);
      repeat (2) @(posedge clk);
      i = 0;
      do
      begin
         apb(1'b0, NVWL_OFS_CTRL, 32'h0);
         i++;
      end
      while (r[0] !== 1'b1 && i < 100);
      chk("done flag", 32'h1, {31'h0, r[0]});
      apb(1'b0, NVWL_OFS_ERR, 32'h0);
      chk("err reg", k == 0 ? 2 : (k == 3 ? 3 : 0), r);
      chk("store writes", 32'(n0 + (k == 1 || k == 3)),
         32'(m_count));
      chk("shadow writes", 32'(s0 + (k == 2)), 32'(sh_cnt));
      if (k == 1)
      begin
         chk("store addr", {24'h0, a}, {24'h0, m_addr});
         chk("store data", d, m_data);
      end
      if (k == 2)
      begin
         chk("shadow addr", {24'h0, a}, {24'h0, wr_addr});
         chk("shadow data", d, wr_data);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {psel, penable, pwrite, abort_cmd} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      rstn = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, NVWL_OFS_CFG, 32'h0);
      chk("cfg reset", 32'h0, r);
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, pslverr});
      $display("test reset done");
      xw(8'h17, 32'h1111_2222, 0);
      setcfg(32'h0000_0040);
      xw(8'h17, 32'h00A4_5678, 1);
      xw(8'h1F, 32'h0000_0001, 0);
      setcfg(32'h0000_0050);
      xw(8'h1F, 32'hA5A5_0F0F, 1);
      xw(8'h20, 32'h0000_0002, 0);
      $display("test exceptions done");
      wr(NVWL_OFS_KEY, {16'h0, NVWL_KEY0, 8'h00});
      wr(NVWL_OFS_KEY, {16'h0, NVWL_KEY1, 8'h00});
      wr(NVWL_OFS_KEY, {16'h0, NVWL_KEY2, 8'h00});
      wr(NVWL_OFS_KEY, {16'h0, NVWL_KEY3, 8'h00});
      wr(NVWL_OFS_KEY, {16'h0, NVWL_KEY4, 8'h00});
      xw(8'h20, 32'hDEAD_BEEF, 1);
      xw(8'h60, 32'h1234_5678, 2);
      xw(8'h21, 32'h0F0F_0F0F, 3);
      $display("test keycode done");
      reset_dut();
      setcfg(32'h0000_006C);
      xw(8'h17, 32'h0000_0017, 1);
      xw(8'h1F, 32'h0000_001F, 0);
      xw(8'h20, 32'h0000_0020, 0);
      xw(8'h57, 32'h0000_0057, 2);
      // Margin only the word written above; rewrite it on a bad read.
      for (int c = 0; c < 3; c++)
      begin
         code = c == 0 ? NVWL_MARGIN_LOW
            : (c == 1 ? NVWL_MARGIN_HIGH : 4'h0);
         thr = c == 0 ? NVWL_THR_LOW
            : (c == 1 ? NVWL_THR_HIGH : NVWL_THR_NORMAL);
         wr(NVWL_OFS_SPECIAL, {28'h0, code});
         apb(1'b0, NVWL_OFS_SPECIAL, 32'h0);
         chk("margin code", {28'h0, code}, r);
         chk("threshold", {30'h0, thr}, {30'h0, read_thr});
         if (c < 2 && m_data !== 32'h0000_0017)
            xw(8'h17, 32'h0000_0017, 1);
      end
      $display("test margin done");
      reset_dut();
      setcfg(32'h0000_0003);
      xw(8'h57, 32'h0000_0057, 0);
      xw(8'h17, 32'h0000_0017, 0);
      $display("test locks done");
      finish_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end
endmodule
